// [cpu_host_model.sv]
// behavioural model of the cpu core and debug host facing the block
`timescale 1ns/10ps
`default_nettype none
module cpu_host_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // requests from the bench
    input  wire logic do_stop,
    input  wire logic do_wait,
    input  wire logic dbg_attach,
    // cpu status toward the block
    output logic      stop_exec,
    output logic      wait_exec,
    output logic      debug_active_in
);
    // one-cycle instruction pulses, stop wins if both are asked
    always_ff @(posedge clk) begin
        stop_exec <= do_stop & ~rst;
        wait_exec <= do_wait & ~do_stop & ~rst;
    end
    // debug host keeps the background unit busy while attached
    always_ff @(posedge clk) begin
        debug_active_in <= dbg_attach & ~rst;
    end
endmodule // cpu_host_model
`default_nettype wire

// [sysmap.sv]
// system map decoder, part code, mode strap, power modes and vectors
`timescale 1ns/10ps
`default_nettype none
module sysmap
    import sysmap_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register and memory port
    input  wire logic [17:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // straps and cpu status
    input  wire logic        mode_select_strap,
    input  wire logic        stop_exec,
    input  wire logic        wait_exec,
    input  wire logic        i_mask,
    input  wire logic        x_mask,
    input  wire logic        debug_active_in,
    input  wire logic        osc_present,
    // interrupt requests, highest priority first
    input  wire logic [8:0]  irq_req,
    input  wire logic        companion_link_irq,
    // wake-up and vector outputs
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             stop_mode,
    output logic             wait_mode,
    output logic             background_debug_unit,
    output logic [15:0]      fetch_vec,
    output logic             vec_valid,
    output logic             wdog_freeze,
    output logic             tick_freeze,
    output logic             flash_clk_en,
    output logic             sys_reset_req,
    output logic [1:0]       reset_cause,
    output logic             ram_sel,
    output logic             flash_sel,
    output logic             info_sel
);
    logic       mode_reg;          // 1 normal, 0 special
    logic       rst_d_reg;         // delayed reset to find release
    logic       info_en_reg;       // info row enable
    logic [7:0] vbase_reg;         // vector base
    logic [7:0] sysctl_reg;        // monitor enable and freeze options
    logic [7:0] cmon_cnt_reg;      // clock monitor counter
    logic       cmon_fail_reg;     // oscillator lost
    logic       illegal_reg;       // illegal access latched
    pwr_state_t pwr_reg;           // power state
    logic [7:0] ram_mem [RAM_WORDS]; // ram, not reset
    logic [7:0] ram_q_reg;         // ram read data
    logic [7:0] reg_q_reg;         // register read data
    region_t    rg;                // decoded region
    region_t    rg_q_reg;          // region of last read
    logic       wake;              // wake condition
    logic [17:0] ram_top;          // last ram address
    logic [17:0] flash_lo;         // first flash address
    logic [17:0] flash_impl_lo;    // first implemented flash address
    logic [15:0] part_code;        // identifier
    vec_if vi ();

    assign ram_top       = RAM_BASE_M1 + RAM_BYTES;
    assign flash_lo      = 18'(FLASH_END - {1'b0, FLASH_BYTES});
    assign flash_impl_lo = 18'(FLASH_END - {1'b0, FLASH_IMPL});
    assign part_code     = {PART_MAJ_FAM, PART_MIN_FAM, PART_MAJ_REV, PART_MIN_REV};

    // region decode
    always_comb begin
        if (addr <= REG_HI)
            rg = RG_REG;
        else if (addr >= INFO_LO && addr <= INFO_HI)
            rg = info_en_reg ? RG_INFO : RG_RSVD;
        else if (addr >= RAM_LO && addr <= ram_top)
            rg = RG_RAM;
        else if (addr >= flash_lo && addr <= FLASH_HI)
            rg = (addr >= flash_impl_lo) ? RG_FLASH : RG_ILLEGAL;
        else
            rg = RG_RSVD;
    end

    assign ram_sel   = (rd | wr) && rg == RG_RAM;
    assign flash_sel = (rd | wr) && rg == RG_FLASH;
    assign info_sel  = (rd | wr) && rg == RG_INFO;
    assign flash_clk_en = 1'b1;

    // reset release detect
    always_ff @(posedge clk) begin
        rst_d_reg <= rst;
    end

    // mode bit: strap at release, software may only leave special mode
    always_ff @(posedge clk) begin
        if (rst)
            mode_reg <= 1'b0;
        else if (rst_d_reg)
            mode_reg <= mode_select_strap;
        else if (wr && rg == RG_REG && addr[9:0] == OFS_MODE && !mode_reg)
            mode_reg <= wdata[MODE_BIT];
    end

    // software control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            info_en_reg <= 1'b0;
            vbase_reg   <= VBASE_RST;
            sysctl_reg  <= SYSCTL_RST;
        end else if (wr && rg == RG_REG) begin
            if (addr[9:0] == OFS_MAPCTL)
                info_en_reg <= wdata[INFO_EN_BIT];
            if (addr[9:0] == OFS_VBASE)
                vbase_reg <= wdata;
            if (addr[9:0] == OFS_SYSCTL)
                sysctl_reg <= wdata;
        end
    end

    // register read data
    always_ff @(posedge clk) begin
        if (rst)
            reg_q_reg <= 8'h00;
        else if (rd) begin
            unique case (addr[9:0])
                OFS_MODE:    reg_q_reg <= {mode_reg, 7'h00};
                OFS_MAPCTL:  reg_q_reg <= {7'h00, info_en_reg};
                OFS_PART_HI: reg_q_reg <= part_code[15:8];
                OFS_PART_LO: reg_q_reg <= part_code[7:0];
                OFS_VBASE:   reg_q_reg <= vbase_reg;
                OFS_SYSCTL:  reg_q_reg <= sysctl_reg;
                OFS_SYSSTAT: reg_q_reg <= {4'h0, illegal_reg, cmon_fail_reg, pwr_reg};
                default:     reg_q_reg <= 8'h00;
            endcase
        end
    end

    // ram array, never cleared
    always_ff @(posedge clk) begin
        if (wr && rg == RG_RAM)
            ram_mem[11'(addr - RAM_LO)] <= wdata;
        if (rd && rg == RG_RAM)
            ram_q_reg <= ram_mem[11'(addr - RAM_LO)];
    end

    // remember region of a read
    always_ff @(posedge clk) begin
        if (rst)
            rg_q_reg <= RG_RSVD;
        else if (rd)
            rg_q_reg <= rg;
    end

    // read mux, reserved reads zero
    always_comb begin
        unique case (rg_q_reg)
            RG_REG:  rdata = reg_q_reg;
            RG_RAM:  rdata = ram_q_reg;
            default: rdata = 8'h00;
        endcase
    end

    // clock monitor
    always_ff @(posedge clk) begin
        if (rst) begin
            cmon_cnt_reg  <= 8'h00;
            cmon_fail_reg <= 1'b0;
        end else if (osc_present || !sysctl_reg[CMON_EN_BIT]) begin
            cmon_cnt_reg <= 8'h00;
        end else if (cmon_cnt_reg == CMON_LIMIT) begin
            cmon_fail_reg <= 1'b1;
        end else begin
            cmon_cnt_reg <= cmon_cnt_reg + 8'h01;
        end
    end

    // illegal flash access
    always_ff @(posedge clk) begin
        if (rst)
            illegal_reg <= 1'b0;
        else if ((rd | wr) && rg == RG_ILLEGAL)
            illegal_reg <= 1'b1;
    end

    assign sys_reset_req = illegal_reg | cmon_fail_reg;
    assign reset_cause   = cmon_fail_reg ? 2'b01 : 2'b00;

    // power state machine
    assign wake = companion_link_irq | vi.valid;
    always_ff @(posedge clk) begin
        if (rst)
            pwr_reg <= PWR_RUN;
        else begin
            unique case (pwr_reg)
                PWR_RUN:  if (stop_exec) pwr_reg <= PWR_STOP;
                          else if (wait_exec) pwr_reg <= PWR_WAIT;
                PWR_WAIT: if (wake) pwr_reg <= PWR_RUN;
                PWR_STOP: if (wake) pwr_reg <= PWR_RUN;
                default:  pwr_reg <= PWR_RUN;
            endcase
        end
    end

    assign stop_mode     = pwr_reg == PWR_STOP;
    assign wait_mode     = pwr_reg == PWR_WAIT;
    assign cpu_clk_en    = pwr_reg == PWR_RUN;
    assign periph_clk_en = pwr_reg != PWR_STOP;

    // debug unit and freeze options
    assign background_debug_unit = !mode_reg | debug_active_in;
    assign wdog_freeze = background_debug_unit & sysctl_reg[WDFRZ_BIT];
    assign tick_freeze = background_debug_unit & sysctl_reg[TKFRZ_BIT];

    // vector encoder hookup
    assign vi.base    = vbase_reg;
    assign vi.i_mask  = i_mask;
    assign vi.x_mask  = x_mask;
    assign vi.req     = irq_req;
    assign vi.link_ie = sysctl_reg[LINKIE_BIT];
    vec_enc u_enc (
        .v (vi.enc)
    );

    // fetch vector: reset vectors fixed, else encoder
    always_comb begin
        vec_valid = 1'b1;
        if (rst || illegal_reg)
            fetch_vec = VEC_SYS;
        else if (cmon_fail_reg)
            fetch_vec = VEC_OSCMON;
        else begin
            fetch_vec = vi.vec;
            vec_valid = vi.valid;
        end
    end
    // note: watchdog reset vector is VEC_WDOG, raised by the watchdog itself

    AST_REGWR: assert property (@(posedge clk) disable iff (rst)
        (wr && rg == RG_REG && addr[9:0] == OFS_VBASE) |=> vbase_reg == $past(wdata))
        else $error("vector base not written");
    AST_RSVD: assert property (@(posedge clk) disable iff (rst)
        (rd && rg == RG_RSVD) |=> rdata == 8'h00)
        else $error("reserved read not zero");
    AST_PART: assert property (@(posedge clk) disable iff (rst)
        (rd && rg == RG_REG && addr[9:0] == OFS_PART_LO) |=> rdata == part_code[7:0])
        else $error("part code low wrong");
    AST_ILL: assert property (@(posedge clk) disable iff (rst)
        ((rd | wr) && rg == RG_ILLEGAL) |=> sys_reset_req)
        else $error("illegal access no reset");
    AST_STOP: assert property (@(posedge clk) disable iff (rst)
        (pwr_reg == PWR_RUN && stop_exec) |=> stop_mode && !periph_clk_en)
        else $error("stop not entered");
    AST_WAKE: assert property (@(posedge clk) disable iff (rst)
        ((wait_mode || stop_mode) && wake) |=> cpu_clk_en)
        else $error("wait not ended");
    AST_MODE: assert property (@(posedge clk)
        $fell(rst) |-> ##1 mode_reg == $past(mode_select_strap))
        else $error("strap not captured");
    AST_CMON: assert property (@(posedge clk) disable iff (rst)
        cmon_fail_reg |-> fetch_vec == VEC_OSCMON || illegal_reg)
        else $error("monitor vector wrong");
    AST_FRZ: assert property (@(posedge clk) disable iff (rst)
        (mode_reg && !debug_active_in) |-> !wdog_freeze && !tick_freeze)
        else $error("freeze outside debug");
endmodule // sysmap
`default_nettype wire

// [sysmap_pkg.sv]
// constants and types for the system map, mode and vector block
// Behaviour
// - registers 0000-03ff; info row gated by enable
// - reserved writes ignored, reads return zero
// - ram from 0800 up to 07ff plus size
// - flash from 40000 minus size to 3ffff
// - unimplemented flash page access causes reset
// - read-only part code at 1a/1b
// - part code has four four-bit fields
// - mode strap captured at reset release
// - mode bit readable, limited software change
// - normal mode fetches from reset vector
// - special mode activates background debug monitor
// - stop entered by instruction, left by wakes
// - wait gates cpu clock until wake
// - peripherals gate own clocks in wait
// - watchdog and tick freeze under debug option
// - clock monitor timeout raises reset when enabled
// - flash clocked and timed by bus clock
// - fixed reset vectors fffe, fffc, fffa
// - link error vectors f2 and f4
// - base plus f8, f6, 80 vectors
// - priority by descending vector offset
// - ram is not cleared by reset
package sysmap_pkg;
    // global map
    localparam logic [17:0] REG_LO       = 18'h00000;
    localparam logic [17:0] REG_HI       = 18'h003ff;
    localparam logic [17:0] INFO_LO      = 18'h00400;
    localparam logic [17:0] INFO_HI      = 18'h0047f;
    localparam logic [17:0] RAM_LO       = 18'h00800;
    localparam logic [17:0] RAM_BASE_M1  = 18'h007ff;
    localparam logic [18:0] FLASH_END    = 19'h40000;
    localparam logic [17:0] FLASH_HI     = 18'h3ffff;
    localparam logic [17:0] RAM_BYTES    = 18'h00800;
    localparam logic [17:0] FLASH_BYTES  = 18'h08000;
    localparam logic [17:0] FLASH_IMPL   = 18'h08000;
    localparam int          RAM_WORDS    = 2048;
    // register offsets
    localparam logic [9:0] OFS_MODE      = 10'h00b;
    localparam logic [9:0] OFS_MAPCTL    = 10'h013;
    localparam logic [9:0] OFS_PART_HI   = 10'h01a;
    localparam logic [9:0] OFS_PART_LO   = 10'h01b;
    localparam logic [9:0] OFS_VBASE     = 10'h121;
    localparam logic [9:0] OFS_SYSCTL    = 10'h030;
    localparam logic [9:0] OFS_SYSSTAT   = 10'h031;
    // field positions
    localparam int MODE_BIT     = 7;
    localparam int INFO_EN_BIT  = 0;
    localparam int CMON_EN_BIT  = 0;
    localparam int WDFRZ_BIT    = 1;
    localparam int TKFRZ_BIT    = 2;
    localparam int LINKIE_BIT   = 3;
    // part code fields, values arbitrary
    localparam logic [3:0] PART_MAJ_FAM = 4'h1;
    localparam logic [3:0] PART_MIN_FAM = 4'h2;
    localparam logic [3:0] PART_MAJ_REV = 4'h0;
    localparam logic [3:0] PART_MIN_REV = 4'h0;
    // reset values
    localparam logic [7:0] VBASE_RST    = 8'hff;
    localparam logic [7:0] SYSCTL_RST   = 8'h00;
    // vectors
    localparam logic [15:0] VEC_SYS     = 16'hfffe;
    localparam logic [15:0] VEC_OSCMON  = 16'hfffc;
    localparam logic [15:0] VEC_WDOG    = 16'hfffa;
    localparam logic [7:0] OFF_TRAP     = 8'hf8;
    localparam logic [7:0] OFF_SOFT     = 8'hf6;
    localparam logic [7:0] OFF_LINKERR  = 8'hf4;
    localparam logic [7:0] OFF_LINKEXT  = 8'hf2;
    localparam logic [7:0] OFF_TICK     = 8'hf0;
    localparam logic [7:0] OFF_SPI      = 8'hd8;
    localparam logic [7:0] OFF_LOCK     = 8'hc6;
    localparam logic [7:0] OFF_FLASH    = 8'hb8;
    localparam logic [7:0] OFF_SPUR     = 8'h80;
    // clock monitor timeout
    localparam int CLK_NS       = 10;
    localparam int CMON_NS      = 2000;
    localparam int CMON_CYC     = CMON_NS / CLK_NS;
    localparam logic [7:0] CMON_LIMIT = 8'(CMON_CYC);
    // power states
    typedef enum logic [1:0] {
        PWR_RUN  = 2'b00,
        PWR_WAIT = 2'b01,
        PWR_STOP = 2'b10
    } pwr_state_t;
    // decoded region
    typedef enum logic [2:0] {
        RG_REG, RG_INFO, RG_RAM, RG_FLASH, RG_RSVD, RG_ILLEGAL
    } region_t;
endpackage

// [tb_sysmap.sv]
// self-checking testbench of the system map, mode and vector block
`timescale 1ns/10ps
`default_nettype none
module tb_sysmap;
    import sysmap_pkg::*;
    logic        clk = 1'b0, rst = 1'b1;       // clock and reset
    logic [17:0] addr = '0;                    // bus address
    logic [7:0]  wdata = '0, rdata, got;       // bus data
    logic        wr = 1'b0, rd = 1'b0;         // bus strobes
    logic        strap = 1'b1, i_mask = 1'b0, x_mask = 1'b0, osc_present = 1'b1;
    logic [8:0]  irq_req = '0;                 // interrupt request levels
    logic        link_irq = 1'b0;              // companion link wake
    logic        do_stop = 1'b0, do_wait = 1'b0, dbg_attach = 1'b0;
    logic        stop_exec, wait_exec, debug_active_in;
    logic        cpu_clk_en, periph_clk_en, stop_mode, wait_mode, bdu, vec_valid;
    logic        wdog_freeze, tick_freeze, flash_clk_en, sys_reset_req;
    logic        ram_sel, flash_sel, info_sel;
    logic [2:0]  sel;                          // info, ram, flash seen during a read
    logic [15:0] fetch_vec;                    // selected vector
    logic [1:0]  reset_cause;                  // cause of the reset request
    logic [31:0] seed = 32'hebcf;              // xorshift state
    int          fail_count = 0, samples_checked = 0, n, k, ex, lie = 1;
    int          mem [int];                    // reference ram contents
    logic [7:0]  offs [0:8] = '{OFF_SPUR, OFF_FLASH, OFF_LOCK, OFF_SPI, OFF_TICK,
                                OFF_LINKEXT, OFF_LINKERR, OFF_SOFT, OFF_TRAP};
    logic [17:0] rsvd [0:3] = '{18'h00400, 18'h00480, 18'h007ff, 18'h01000};

    // free-running 100 MHz clock
    always #5 clk = ~clk;

    sysmap u_sysmap (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .mode_select_strap(strap), .stop_exec(stop_exec),
        .wait_exec(wait_exec), .i_mask(i_mask), .x_mask(x_mask),
        .debug_active_in(debug_active_in), .osc_present(osc_present), .irq_req(irq_req),
        .companion_link_irq(link_irq), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .background_debug_unit(bdu), .fetch_vec(fetch_vec), .vec_valid(vec_valid),
        .wdog_freeze(wdog_freeze), .tick_freeze(tick_freeze), .flash_clk_en(flash_clk_en),
        .sys_reset_req(sys_reset_req), .reset_cause(reset_cause), .ram_sel(ram_sel),
        .flash_sel(flash_sel), .info_sel(info_sel));

    cpu_host_model u_cpu_host_model (.clk(clk), .rst(rst), .do_stop(do_stop),
        .do_wait(do_wait), .dbg_attach(dbg_attach), .stop_exec(stop_exec),
        .wait_exec(wait_exec), .debug_active_in(debug_active_in));

    // pseudo-random source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] act);
        samples_checked++;
        if (exp !== act) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, act);
        end
    endtask

    // one-cycle write strobe
    task automatic wr_byte(input logic [17:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd_byte(input logic [17:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        #1 sel = {info_sel, ram_sel, flash_sel};
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // reset with a given strap level, access allowed two edges after release
    task automatic do_reset(input logic s);
        @(posedge clk);
        strap <= s;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // settle a few cycles after the last change
    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // counts and verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog against a hung run
    initial begin
        #400000;
        fail_count++;
        stop_test();
    end

    initial begin
        do_reset(1'b1);
        // part code is read-only and split high then low
        wr_byte(18'h0001a, 8'h5a);
        rd_byte(18'h0001a, got);
        check("part_hi", {PART_MAJ_FAM, PART_MIN_FAM}, got);
        rd_byte(18'h0001b, got);
        check("part_lo", {PART_MAJ_REV, PART_MIN_REV}, got);
        $display("part code test done");
        // reserved space swallows writes and reads zero, info row gated
        for (k = 0; k < 4; k++) begin
            wr_byte(rsvd[k], xs() | 8'h01);
            rd_byte(rsvd[k], got);
            check("rsvd_data", 0, got);
            check("rsvd_sel", 0, sel);
        end
        wr_byte({8'h00, OFS_MAPCTL}, 8'h01);
        rd_byte(18'h00400, got);
        check("info_sel", 3'b100, sel);
        rd_byte(18'h003ff, got);
        check("reg_top_sel", 0, sel);
        $display("map test done");
        // ram keeps random bytes at random and edge addresses
        for (k = 0; k < 20; k++) begin
            n = (k == 0) ? 'h800 : (k == 1) ? 'h7ff + RAM_WORDS : 'h800 + xs() % RAM_WORDS;
            mem[n] = xs() & 8'hff;
            wr_byte(18'(n), 8'(mem[n]));
        end
        foreach (mem[a]) begin
            rd_byte(18'(a), got);
            check("ram_data", mem[a], got);
            check("ram_sel", 3'b010, sel);
        end
        // flash window edges, nothing illegal when all pages exist
        rd_byte(FLASH_HI, got);
        check("flash_top", 3'b001, sel);
        rd_byte(18'(FLASH_END - 19'(FLASH_BYTES)), got);
        check("flash_low", 3'b001, sel);
        rd_byte(18'(FLASH_END - 19'(FLASH_BYTES) - 19'h1), got);
        check("below_flash", 0, sel);
        check("no_illegal", 0, sys_reset_req);
        check("flash_clk", 1, flash_clk_en);
        $display("memory test done");
        // mode strap capture and one-way switch from special to normal
        do_reset(1'b0);
        rd_byte({8'h00, OFS_MODE}, got);
        check("mode_special", 8'h00, got);
        check("bdu_special", 1, bdu);
        wr_byte({8'h00, OFS_MODE}, 8'h80);
        rd_byte({8'h00, OFS_MODE}, got);
        check("mode_up", 8'h80, got);
        wr_byte({8'h00, OFS_MODE}, 8'h00);
        rd_byte({8'h00, OFS_MODE}, got);
        check("mode_stuck", 8'h80, got);
        check("bdu_normal", 0, bdu);
        // freeze options only while debug is active
        wr_byte({8'h00, OFS_SYSCTL}, 8'h0e);
        settle(1);
        check("frz_idle", 0, {wdog_freeze, tick_freeze});
        dbg_attach <= 1'b1;
        settle(3);
        check("frz_dbg", 3, {wdog_freeze, tick_freeze});
        check("bdu_dbg", 1, bdu);
        dbg_attach <= 1'b0;
        $display("mode test done");
        // vector selection over random request sets and masks
        wr_byte({8'h00, OFS_VBASE}, 8'hc3);
        for (n = 0; n < 60; n++) begin
            // second half runs with the link external enable off
            if (n == 30) begin
                wr_byte({8'h00, OFS_SYSCTL}, 8'h06);
                lie = 0;
            end
            irq_req <= (n == 0) ? 9'h1ff : 9'(xs());
            i_mask <= xs() & 1;
            x_mask <= xs() & 1;
            settle(1);
            ex = -1;
            for (k = 8; k >= 0 && ex < 0; k--)
                if (irq_req[k] && !((k >= 1 && k <= 5 && i_mask) || (k == 6 && x_mask) ||
                                    (k == 5 && lie == 0)))
                    ex = k;
            check("vec_valid", ex >= 0, vec_valid);
            if (ex >= 0)
                check("vec_addr", {8'hc3, offs[ex]}, fetch_vec);
        end
        irq_req <= '0;
        $display("vector test done");
        // stop held by a masked request, woken by the link interrupt
        i_mask <= 1'b1;
        do_stop <= 1'b1;
        @(posedge clk);
        do_stop <= 1'b0;
        settle(4);
        check("stop_in", 2'b10, {stop_mode, cpu_clk_en});
        irq_req <= 9'h010;
        settle(6);
        check("stop_masked", 1, stop_mode);
        link_irq <= 1'b1;
        settle(4);
        check("stop_wake", 0, stop_mode);
        link_irq <= 1'b0;
        irq_req <= '0;
        // wait keeps peripherals clocked and ends on an unmasked request
        i_mask <= 1'b0;
        do_wait <= 1'b1;
        @(posedge clk);
        do_wait <= 1'b0;
        settle(4);
        check("wait_in", 3'b101, {wait_mode, cpu_clk_en, periph_clk_en});
        irq_req <= 9'h008;
        settle(4);
        check("wait_wake", 2'b01, {wait_mode, cpu_clk_en});
        irq_req <= '0;
        $display("power test done");
        // clock monitor reset after the oscillator disappears
        wr_byte({8'h00, OFS_SYSCTL}, 8'h01);
        osc_present <= 1'b0;
        settle(CMON_CYC - 20);
        check("cmon_early", 0, sys_reset_req);
        settle(40);
        check("cmon_reset", 1, sys_reset_req);
        check("cmon_cause", 2'b01, reset_cause);
        osc_present <= 1'b1;
        do_reset(1'b1);
        check("cmon_clear", 0, sys_reset_req);
        $display("monitor test done");
        stop_test();
    end
endmodule // tb_sysmap
`default_nettype wire

// [vec_enc.sv]
// priority encoder of interrupt vectors
`timescale 1ns/10ps
`default_nettype none
module vec_enc
    import sysmap_pkg::*;
(
    vec_if.enc v
);
    // offset table in priority order, highest first
    localparam logic [7:0] OFS [9] = '{OFF_TRAP, OFF_SOFT, OFF_LINKERR, OFF_LINKEXT,
                                       OFF_TICK, OFF_SPI, OFF_LOCK, OFF_FLASH, OFF_SPUR};
    logic [8:0] eff;        // requests after masking
    // masking by i and x bits and local enables
    always_comb begin
        eff    = v.req;
        eff[6] = v.req[6] & ~v.x_mask;
        eff[5] = v.req[5] & ~v.i_mask & v.link_ie;
        eff[4] = v.req[4] & ~v.i_mask;
        eff[3] = v.req[3] & ~v.i_mask;
        eff[2] = v.req[2] & ~v.i_mask;
        eff[1] = v.req[1] & ~v.i_mask;
    end
    // highest offset wins: scan upward so the last hit is the highest source
    always_comb begin
        v.valid = 1'b0;
        v.vec   = 16'h0000;
        for (int k = 0; k <= 8; k++) begin
            if (eff[k]) begin
                v.valid = 1'b1;
                v.vec   = {v.base, OFS[8 - k]};
            end
        end
    end
endmodule // vec_enc
`default_nettype wire

// [vec_if.sv]
// request bundle between the vector encoder and the top
`timescale 1ns/10ps
`default_nettype none
interface vec_if;
    logic [7:0]  base;      // vector base high byte
    logic        i_mask;    // i bit
    logic        x_mask;    // x bit
    logic [8:0]  req;       // pending sources, highest priority at 8
    logic        link_ie;   // local link external enable
    logic        valid;     // a vector is selected
    logic [15:0] vec;       // selected vector address
    modport enc (input base, i_mask, x_mask, req, link_ie, output valid, vec);
    modport top (output base, i_mask, x_mask, req, link_ie, input valid, vec);
endinterface
`default_nettype wire
